// ---- mrc_defs.vh ----
`ifndef MRC_DEFS_VH
`define MRC_DEFS_VH
// register byte addresses on the bus
// the option byte keeps its word index; its byte address is four times that
`define MRC_IDX_OPTION 16'hFFFF
`define MRC_ADDR_OPTION {`MRC_IDX_OPTION, 2'b00}
`define MRC_ADDR_PMODE0 18'h0_0004
`define MRC_ADDR_PMODE1 18'h0_0008
`define MRC_ADDR_STATUS 18'h0_000C
`define MRC_ADDR_CAUSE 18'h0_0010
// option byte layout
`define MRC_OPT_RESET 8'hFF
`define MRC_OPT_WDT_AUTO_DIS 0
`define MRC_OPT_CP_GATE 2
`define MRC_OPT_CP_BIT 3
`define MRC_OPT_CSP_INIT 7
`define MRC_OPT_FORCE1 8'h52
`define MRC_OPT_KEEP 8'h8D
// processor mode bits
`define MRC_PMODE0_SWRST 3
`define MRC_PMODE1_WDTSEL 2
// cause bit positions
`define MRC_SRC_PIN 0
`define MRC_SRC_POR 1
`define MRC_SRC_VM1 2
`define MRC_SRC_VM2 3
`define MRC_SRC_WDT 4
`define MRC_SRC_SW 5
`define MRC_NSRC 6
// timing
`define MRC_POR_COUNT 32
`define MRC_CPU_DIV 8
`define MRC_PIN_MIN_NS 10000
`define MRC_CLK_NS 4
`endif

// ---- mrc_reset_ctrl.v ----
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ns
// How it works
// [R01] six reset sources gathered here
// [R02] low reset pin holds pins, cpu, registers
// [R03] listed port pins forced input during reset
// [R04] release restarts cpu at reset vector
// [R05] cpu clock becomes slow oscillator divided eight
// [R06] ram never cleared; undefined flag raised
// [R07] external pin low at least ten microseconds
// [R08] power-up pin held low through settle time
// [R09] power-on counts 32 slow clocks before release
// [R10] level one monitor trip resets device
// [R11] level two monitor trip resets device
// [R12] warm resets keep some registers
// [R13] watchdog underflow resets when select bit set
// [R14] writing software reset bit resets device
// [R15] option bit zero starts watchdog at reset
// [R16] option bit seven at zero enables count source protect
// [R17] code protect needs gate one, bit zero
// [R18] option erased FFh, reserved bits fixed
// [R19] sources ORed, release synced to slow clock
`include "mrc_defs.vh"
module mrc_reset_ctrl #(
    parameter CPU_DIV = `MRC_CPU_DIV,
    parameter POR_COUNT = `MRC_POR_COUNT
) (
    input wire i_clk,
    input wire i_rst_b,
    input wire i_slow_tick,
    input wire i_reset_pin_b,
    input wire i_power_ok,
    input wire i_vmon1_trip,
    input wire i_vmon2_trip,
    input wire i_wdt_underflow,
    input wire i_ram_write,
    input wire [7:0] i_opt_prog_data,
    input wire i_opt_prog_we,
    input wire i_opt_erase,
    output reg o_sys_reset,
    output reg o_cold_reset,
    output reg o_start_vector,
    output reg o_cpu_clk_en,
    output reg o_cpu_clk_sel_slow,
    output reg o_ports_input,
    output reg o_ram_undefined,
    output reg o_wdt_start,
    output reg o_csp_enable,
    output reg o_code_protect,
    input wire [17:0] i_s_axi_awaddr,
    input wire i_s_axi_awvalid,
    output wire o_s_axi_awready,
    input wire [31:0] i_s_axi_wdata,
    input wire [3:0] i_s_axi_wstrb,
    input wire i_s_axi_wvalid,
    output wire o_s_axi_wready,
    output reg [1:0] o_s_axi_bresp,
    output reg o_s_axi_bvalid,
    input wire i_s_axi_bready,
    input wire [17:0] i_s_axi_araddr,
    input wire i_s_axi_arvalid,
    output wire o_s_axi_arready,
    output reg [31:0] o_s_axi_rdata,
    output reg [1:0] o_s_axi_rresp,
    output reg o_s_axi_rvalid,
    input wire i_s_axi_rready
);
    localparam ST_HOLD = 2'd0;
    localparam ST_SYNC = 2'd1;
    localparam ST_RUN = 2'd2;

    reg [7:0] option_reg;
    reg [7:0] pmode0_reg;
    reg [7:0] pmode1_reg;
    reg [5:0] cause_reg;
    reg [1:0] state_reg;
    reg [5:0] por_cnt_reg;
    reg [3:0] div_cnt_reg;
    reg por_done_reg;
    reg warm_only_reg;
    reg [17:0] aw_addr_reg;
    reg aw_full_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;
    reg w_full_reg;
    wire [5:0] src_vec;
    wire any_src;
    wire cold_src;
    wire wr_fire;

    // programmed option byte, reserved bits forced to legal values; erase loads FFh as is
    function [7:0] opt_legal;
        input [7:0] v;
        begin
            opt_legal = (v & `MRC_OPT_KEEP) | `MRC_OPT_FORCE1; // R18
        end
    endfunction

    // source vector; watchdog only counts when its select bit is set
    assign src_vec[`MRC_SRC_PIN] = ~i_reset_pin_b & i_power_ok; // R02
    assign src_vec[`MRC_SRC_POR] = ~por_done_reg; // R09
    assign src_vec[`MRC_SRC_VM1] = i_vmon1_trip; // R10
    assign src_vec[`MRC_SRC_VM2] = i_vmon2_trip; // R11
    assign src_vec[`MRC_SRC_WDT] = i_wdt_underflow & pmode1_reg[`MRC_PMODE1_WDTSEL]; // R13
    assign src_vec[`MRC_SRC_SW] = pmode0_reg[`MRC_PMODE0_SWRST]; // R14
    assign any_src = |src_vec; // R01 R19
    assign cold_src = src_vec[`MRC_SRC_PIN] | src_vec[`MRC_SRC_POR]; // R12

    // power-on counter: 32 slow ticks after supply good
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            por_cnt_reg <= 6'h00;
            por_done_reg <= 1'b0;
        end else if (!i_power_ok) begin
            por_cnt_reg <= 6'h00;
            por_done_reg <= 1'b0;
        end else if (i_slow_tick && !por_done_reg) begin
            if (por_cnt_reg == POR_COUNT - 1)
                por_done_reg <= 1'b1; // R09
            por_cnt_reg <= por_cnt_reg + 6'h01;
        end
    end

    // reset sequencer; release waits for a slow-clock tick so it is aligned
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg <= ST_HOLD;
            o_sys_reset <= 1'b1;
            o_cold_reset <= 1'b1;
            o_start_vector <= 1'b0;
            o_ports_input <= 1'b1;
            o_cpu_clk_sel_slow <= 1'b1;
            warm_only_reg <= 1'b0;
        end else begin
            o_start_vector <= 1'b0;
            case (state_reg)
                ST_HOLD: begin
                    o_sys_reset <= 1'b1; // R02
                    o_ports_input <= 1'b1; // R03
                    o_cpu_clk_sel_slow <= 1'b1; // R05
                    if (!any_src)
                        state_reg <= ST_SYNC;
                end
                ST_SYNC: begin
                    if (any_src)
                        state_reg <= ST_HOLD;
                    else if (i_slow_tick) begin
                        state_reg <= ST_RUN; // R19
                        o_sys_reset <= 1'b0;
                        o_cold_reset <= 1'b0;
                        o_ports_input <= 1'b0;
                        o_start_vector <= 1'b1; // R04
                    end
                end
                ST_RUN: begin
                    if (any_src) begin
                        state_reg <= ST_HOLD;
                        o_sys_reset <= 1'b1;
                        o_ports_input <= 1'b1;
                        o_cold_reset <= cold_src; // R12
                        warm_only_reg <= ~cold_src;
                    end
                end
                default: state_reg <= ST_HOLD;
            endcase
        end
    end

    // cpu clock enable: slow tick divided by eight
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            div_cnt_reg <= 4'h0;
            o_cpu_clk_en <= 1'b0;
        end else begin
            o_cpu_clk_en <= 1'b0;
            // a fresh source also stops the enable, else one pulse slips into reset
            if (o_sys_reset || any_src) begin
                div_cnt_reg <= 4'h0;
            end else if (i_slow_tick) begin
                if (div_cnt_reg == CPU_DIV - 1) begin
                    div_cnt_reg <= 4'h0;
                    o_cpu_clk_en <= o_cpu_clk_sel_slow; // R05
                end else begin
                    div_cnt_reg <= div_cnt_reg + 4'h1;
                end
            end
        end
    end

    // ram is never cleared; a reset mid-write or a watchdog trip spoils it
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            o_ram_undefined <= 1'b0;
        else if ((any_src && i_ram_write) || src_vec[`MRC_SRC_WDT])
            o_ram_undefined <= 1'b1; // R06
        else if (wr_fire && aw_addr_reg == `MRC_ADDR_STATUS && w_data_reg[0])
            o_ram_undefined <= 1'b0;
    end

    // option byte decode, latched while reset is asserted
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_wdt_start <= 1'b0;
            o_csp_enable <= 1'b0;
            o_code_protect <= 1'b0;
        end else if (o_sys_reset) begin
            o_wdt_start <= ~option_reg[`MRC_OPT_WDT_AUTO_DIS]; // R15
            o_csp_enable <= ~option_reg[`MRC_OPT_CSP_INIT]; // R16
            o_code_protect <= option_reg[`MRC_OPT_CP_GATE] &
                ~option_reg[`MRC_OPT_CP_BIT]; // R17
        end
    end

    // axi write channels, taken in either order
    assign o_s_axi_awready = ~aw_full_reg;
    assign o_s_axi_wready = ~w_full_reg;
    assign wr_fire = aw_full_reg & w_full_reg & ~o_s_axi_bvalid;
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_addr_reg <= 18'h0_0000;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp <= 2'b00;
        end else begin
            if (i_s_axi_awvalid && !aw_full_reg) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= i_s_axi_awaddr;
            end
            if (i_s_axi_wvalid && !w_full_reg) begin
                w_full_reg <= 1'b1;
                w_data_reg <= i_s_axi_wdata;
                w_strb_reg <= i_s_axi_wstrb;
            end
            if (wr_fire) begin
                o_s_axi_bvalid <= 1'b1;
                o_s_axi_bresp <= (aw_addr_reg == `MRC_ADDR_OPTION ||
                    aw_addr_reg == `MRC_ADDR_PMODE0 || aw_addr_reg == `MRC_ADDR_PMODE1 ||
                    aw_addr_reg == `MRC_ADDR_STATUS || aw_addr_reg == `MRC_ADDR_CAUSE) ?
                    2'b00 : 2'b10;
            end else if (o_s_axi_bvalid && i_s_axi_bready) begin
                o_s_axi_bvalid <= 1'b0;
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
            end
        end
    end

    // registers; warm resets keep mode 1 and the cause log
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            option_reg <= `MRC_OPT_RESET; // R18
            pmode0_reg <= 8'h00;
            pmode1_reg <= 8'h00;
            cause_reg <= 6'h00;
        end else begin
            if (o_sys_reset) begin
                pmode0_reg <= 8'h00;
                if (o_cold_reset && !warm_only_reg)
                    pmode1_reg <= 8'h00; // R12
            end
            if (state_reg == ST_RUN && any_src)
                cause_reg <= cause_reg | src_vec;
            if (i_opt_erase)
                option_reg <= `MRC_OPT_RESET;
            else if (i_opt_prog_we)
                option_reg <= opt_legal(option_reg & i_opt_prog_data);
            if (wr_fire && w_strb_reg[0] && !o_sys_reset) begin
                case (aw_addr_reg)
                    `MRC_ADDR_PMODE0: pmode0_reg <= w_data_reg[7:0]; // R14
                    `MRC_ADDR_PMODE1: pmode1_reg <= w_data_reg[7:0];
                    `MRC_ADDR_CAUSE: cause_reg <= (cause_reg & ~w_data_reg[5:0]) |
                        ((state_reg == ST_RUN && any_src) ? src_vec : 6'h00);
                    default: ;
                endcase
            end
        end
    end

    // axi read channel
    assign o_s_axi_arready = ~o_s_axi_rvalid;
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata <= 32'h0000_0000;
            o_s_axi_rresp <= 2'b00;
        end else if (i_s_axi_arvalid && !o_s_axi_rvalid) begin
            o_s_axi_rvalid <= 1'b1;
            o_s_axi_rresp <= 2'b00;
            case (i_s_axi_araddr)
                `MRC_ADDR_OPTION: o_s_axi_rdata <= {24'h00_0000, option_reg};
                `MRC_ADDR_PMODE0: o_s_axi_rdata <= {24'h00_0000, pmode0_reg};
                `MRC_ADDR_PMODE1: o_s_axi_rdata <= {24'h00_0000, pmode1_reg};
                `MRC_ADDR_STATUS: o_s_axi_rdata <= {26'h000_0000, o_code_protect,
                    o_csp_enable, o_wdt_start, o_ram_undefined, state_reg};
                `MRC_ADDR_CAUSE: o_s_axi_rdata <= {26'h000_0000, cause_reg};
                default: begin
                    o_s_axi_rdata <= 32'h0000_0000;
                    o_s_axi_rresp <= 2'b10;
                end
            endcase
        end else if (o_s_axi_rvalid && i_s_axi_rready) begin
            o_s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// ---- mrc_ext_sup.sv ----
`timescale 1ns/1ns
// external supervisor: holds the pin low while supply rises, then the minimum low time
module mrc_ext_sup #(parameter MIN_CYC = 2500) (
    input wire i_clk,
    input wire i_req,
    output reg o_pin_b,
    output reg o_pwr_ok
);
    integer cnt = 0;
    initial o_pin_b = 1'b0;
    initial o_pwr_ok = 1'b0;
    // a request restarts the count, so every low pulse lasts the full minimum
    always @(posedge i_clk) begin
        cnt <= i_req ? 0 : cnt + 1;
        if (i_req) o_pin_b <= 1'b0;
        if (cnt == 20) o_pwr_ok <= 1'b1;
        if (cnt == 40 + MIN_CYC) o_pin_b <= 1'b1;
    end
endmodule

// ---- mrc_reset_ctrl_chk.sv ----
`timescale 1ns/1ns
// watches reset outputs against pin, supply, monitors and tick
module mrc_reset_ctrl_chk (
    input wire i_clk,
    input wire i_rst_b,
    input wire i_slow_tick,
    input wire i_reset_pin_b,
    input wire i_power_ok,
    input wire i_vmon1_trip,
    input wire i_vmon2_trip,
    input wire o_sys_reset,
    input wire o_start_vector,
    input wire o_cpu_clk_en,
    input wire o_ports_input
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // release: reset falls, then a single vector pulse
    sequence rel_s;
        $fell(o_sys_reset);
    endsequence
    sequence vec_s;
        o_start_vector ##1 !o_start_vector;
    endsequence
    pin_hold_a: assert property ((!i_reset_pin_b) [*4] |-> o_sys_reset)
        else $error("pin low no reset");
    port_in_a: assert property (o_sys_reset [*2] |-> o_ports_input)
        else $error("ports not input");
    vec_after_a: assert property (rel_s |-> ##[0:1] vec_s)
        else $error("bad vector pulse");
    clk_idle_a: assert property (o_sys_reset |-> !o_cpu_clk_en)
        else $error("cpu clock in reset");
    vec_power_a: assert property (o_start_vector |-> i_power_ok)
        else $error("start without supply");
    vmon_one_a: assert property (i_vmon1_trip |-> ##[0:3] o_sys_reset)
        else $error("monitor one missed");
    vmon_two_a: assert property (i_vmon2_trip |-> ##[0:3] o_sys_reset)
        else $error("monitor two missed");
    rel_sync_a: assert property (rel_s |-> $past(i_slow_tick) || $past(i_slow_tick, 2))
        else $error("release off tick");
endmodule
bind mrc_reset_ctrl mrc_reset_ctrl_chk i_chk (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_slow_tick(i_slow_tick),
    .i_reset_pin_b(i_reset_pin_b), .i_power_ok(i_power_ok), .i_vmon1_trip(i_vmon1_trip),
    .i_vmon2_trip(i_vmon2_trip), .o_sys_reset(o_sys_reset), .o_start_vector(o_start_vector),
    .o_cpu_clk_en(o_cpu_clk_en), .o_ports_input(o_ports_input)
);

// ---- tb_top.sv ----
`timescale 1ns/1ns
`include "mrc_defs.vh"
module tb_top;
    localparam [31:0] zero = 32'h0000_0000;
    reg i_clk = 1'h0, rst_b = 1'h0, tick = 1'h0, req = 1'h0, v1 = 1'h0, v2 = 1'h0;
    reg wdt = 1'h0, opwe = 1'h0, oper = 1'h0, awv = 1'h0, wv = 1'h0, bry = 1'h0;
    reg arv = 1'h0, rry = 1'h0, ramw = 1'h0;
    reg [7:0] opd = 8'h00;
    reg [17:0] awa = 18'h0_0000, ara = 18'h0_0000;
    reg [31:0] wd = zero, rv;
    reg [1:0] rr, br;
    wire pin_b, pwr, srst, cold, sel, pin_in, ramu, wst, csp, cp, awr, wr_r, bv, arr, rvl;
    wire [1:0] rrs, brs;
    wire [31:0] rd_d;
    integer n_mismatch = 0, n_checks = 0, tc = 0;
    // 250 MHz clock, slow oscillator tick every fourth cycle
    always #2 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        tc <= tc + 1;
        tick <= (tc % 4 == 3);
    end
    mrc_ext_sup i_mrc_ext_sup (.i_clk(i_clk), .i_req(req), .o_pin_b(pin_b), .o_pwr_ok(pwr));
    mrc_reset_ctrl #(.CPU_DIV(2), .POR_COUNT(4)) i_mrc_reset_ctrl (
        .i_clk(i_clk), .i_rst_b(rst_b), .i_slow_tick(tick), .i_reset_pin_b(pin_b),
        .i_power_ok(pwr), .i_vmon1_trip(v1), .i_vmon2_trip(v2), .i_wdt_underflow(wdt),
        .i_ram_write(ramw), .i_opt_prog_data(opd), .i_opt_prog_we(opwe), .i_opt_erase(oper),
        .o_sys_reset(srst), .o_cold_reset(cold), .o_start_vector(), .o_cpu_clk_en(),
        .o_cpu_clk_sel_slow(sel), .o_ports_input(pin_in), .o_ram_undefined(ramu),
        .o_wdt_start(wst), .o_csp_enable(csp), .o_code_protect(cp),
        .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
        .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'h1), .i_s_axi_wvalid(wv), .o_s_axi_wready(wr_r),
        .o_s_axi_bresp(brs), .o_s_axi_bvalid(bv), .i_s_axi_bready(bry),
        .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
        .o_s_axi_rdata(rd_d), .o_s_axi_rresp(rrs), .o_s_axi_rvalid(rvl), .i_s_axi_rready(rry)
    );
    task report_and_stop(input t);
        n_mismatch = n_mismatch + t;
        if (n_mismatch == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        n_checks = n_checks + 1;
        if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    // bounded wait for the reset output to reach a level
    task wt(input v);
        integer n;
        for (n = 0; srst !== v && n < 4000; n = n + 1) @(posedge i_clk);
        if (n >= 4000) report_and_stop(1'h1);
    endtask
    // one bus access; each valid drops only once its ready was seen
    task ax(input w, input [17:0] a, input [31:0] d);
        integer n;
        awa <= a;
        ara <= a;
        wd <= d;
        {awv, wv, bry} <= {3{w}};
        {arv, rry} <= {2{!w}};
        @(posedge i_clk);
        for (n = 0; !(w ? bv : rvl) && n < 4000; n = n + 1) begin
            if (awr) awv <= 1'h0;
            if (wr_r) wv <= 1'h0;
            if (arr) arv <= 1'h0;
            @(posedge i_clk);
        end
        rv = rd_d;
        rr = rrs;
        br = brs;
        {awv, wv, arv, bry, rry} <= 5'h00;
        @(posedge i_clk);
        if (n >= 4000) report_and_stop(1'h1);
    endtask
    task t_dflt;
        ax(1'h0, `MRC_ADDR_OPTION, zero);
        chk("option", 32'h0000_008d, rv & 32'h0000_008d);
        chk("decode", zero, {wst, csp, cp});
        chk("clk sel", 32'h0000_0001, sel);
        ax(1'h0, 18'h0_0020, zero);
        chk("bad rdata", zero, rv);
        chk("bad rresp", 32'h0000_0002, rr);
        ax(1'h1, 18'h0_0020, zero);
        chk("bad bresp", 32'h0000_0002, br);
    endtask
    // level source held until the reset is seen; cause bit must match
    task t_trip(input [2:0] s);
        ax(1'h1, `MRC_ADDR_CAUSE, 32'h0000_003f);
        {wdt, v2, v1} <= s;
        wt(1'h1);
        {wdt, v2, v1} <= 3'h0;
        wt(1'h0);
        ax(1'h0, `MRC_ADDR_CAUSE, zero);
        chk("cause", {s, 2'h0}, rv);
        chk("ram state", s[2], ramu);
    endtask
    task t_warm;
        ax(1'h1, `MRC_ADDR_PMODE1, 32'h0000_0004);
        t_trip(3'h4);
        chk("ram undef", 32'h0000_0001, ramu);
        ax(1'h1, `MRC_ADDR_STATUS, 32'h0000_0001);
        chk("ram clr", zero, ramu);
        ax(1'h1, `MRC_ADDR_PMODE0, 32'h0000_0008);
        wt(1'h1);
        chk("cold", zero, cold);
        wt(1'h0);
        ax(1'h0, `MRC_ADDR_PMODE1, zero);
        chk("pm1 kept", 32'h0000_0004, rv);
        ax(1'h1, `MRC_ADDR_PMODE1, zero);
        wdt <= 1'h1;
        repeat (20) @(posedge i_clk);
        chk("no wdt rst", zero, srst);
        wdt <= 1'h0;
    endtask
    // erase, program, try a bus write, then decode at a software reset
    task t_opt(input [7:0] d, input [2:0] e);
        oper <= 1'h1;
        @(posedge i_clk);
        oper <= 1'h0;
        opd <= d;
        opwe <= 1'h1;
        @(posedge i_clk);
        opwe <= 1'h0;
        ax(1'h1, `MRC_ADDR_OPTION, zero);
        ax(1'h1, `MRC_ADDR_PMODE0, 32'h0000_0008);
        wt(1'h1);
        wt(1'h0);
        chk("decode", e, {wst, csp, cp});
        ax(1'h0, `MRC_ADDR_OPTION, zero);
        chk("option", d & 8'h8d, rv & 32'h0000_008d);
    endtask
    // pin reset during a ram write; cold reset must clear mode 1
    task t_pin;
        ax(1'h1, `MRC_ADDR_PMODE1, 32'h0000_0004);
        req <= 1'h1;
        ramw <= 1'h1;
        @(posedge i_clk);
        req <= 1'h0;
        wt(1'h1);
        ramw <= 1'h0;
        repeat (100) @(posedge i_clk);
        chk("ram write", 32'h0000_0001, ramu);
        chk("held", 32'h0000_0003, {srst, pin_in});
        chk("cold", 32'h0000_0001, cold);
        wt(1'h0);
        chk("ports", zero, pin_in);
        ax(1'h0, `MRC_ADDR_PMODE1, zero);
        chk("pm1 cleared", zero, rv);
    endtask
    initial begin
        repeat (10) @(posedge i_clk);
        rst_b <= 1'h1;
        wt(1'h0);
        t_dflt;
        t_warm;
        t_trip(3'h1);
        t_trip(3'h2);
        t_opt(8'h00, 3'h6);
        t_opt(8'hf7, 3'h1);
        t_pin;
        report_and_stop(1'h0);
    end
endmodule
